// [rtl/flash_host.sv]
// host controller driving a serial nor flash over its spi pins
`timescale 1ns/1ps
`include "flash_host_map.svh"
module flash_host import flash_host_pkg::*; #(
	parameter int SCLK_HALF = `SCLK_HALF_CYC,
	parameter int STATUS_WRITE_CYC = `STATUS_WRITE_MAX_CYC,
	parameter int ERASE_GAP_CYC = `ERASE_GAP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_opcode,
	input wire logic [23:0] cmd_addr,
	input wire logic [15:0] cmd_len,
	output logic cmd_done,
	// write data stream
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	// read data stream and busy indication
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic dev_busy,
	// flash pins
	output logic cs_n,
	output logic sclk,
	output logic io0_o,
	output logic io0_oe,
	input wire logic io0_i,
	output logic io1_o,
	output logic io1_oe,
	input wire logic io1_i
);
	state_t st_q;
	phase_t ph_q;
	cmd_info_t inf_q;
	logic [7:0] op_q, main_q, pre_q, sh_q, rx_q, wb_q, div_q;
	logic [7:0] rx_n;
	logic [23:0] addr_q;
	logic [15:0] len_q;
	logic [2:0] cnt_q, bit_q;
	logic [18:0] wait_q, wsr_q;
	logic [12:0] gap_q;
	logic [1:0] s1_q, s2_q;
	logic pre_v_q, pend_q, act_q, need_q, dual_q, ended_q, erase_last_q, wb_full_q, cs_q;
	logic take, use_wb;

	// command table: address, dummy, line use, data direction, latch need
	function automatic cmd_info_t decode(input logic [7:0] op);
		cmd_info_t c;
		c = '0;
		c.known = 1'h1;
		case (op)
			`OP_ARRAY_READ, `OP_MAKER_DEVICE_ID_READ, `OP_DEEP_SLEEP_RELEASE: begin
				c.adr = 2'h3;
				c.rd = 1'h1;
			end
			`OP_FAST_ARRAY_READ, `OP_OTP_AREA_READ, `OP_PARAM_TABLE_READ: begin
				c.adr = 2'h3;
				c.dmy = 3'h1;
				c.rd = 1'h1;
			end
			`OP_DUAL_OUTPUT_READ, `OP_DUAL_IO_READ, `OP_DUAL_MAKER_DEVICE_ID_READ: begin
				c.adr = 2'h3;
				c.dmy = 3'h1;
				c.dual_adr = (op == `OP_DUAL_IO_READ);
				c.dual_data = 1'h1;
				c.rd = 1'h1;
			end
			`OP_PAGE_ERASE, `OP_SECTOR_ERASE, `OP_BLOCK_ERASE_32K, `OP_BLOCK_ERASE_64K,
			`OP_OTP_AREA_ERASE: begin
				c.adr = 2'h3;
				c.write_enable_cmd = 1'h1;
			end
			`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: c.write_enable_cmd = 1'h1;
			`OP_PAGE_PROGRAM, `OP_OTP_AREA_PROGRAM, `OP_DUAL_INPUT_PROGRAM: begin
				c.adr = 2'h3;
				c.dual_data = (op == `OP_DUAL_INPUT_PROGRAM);
				c.wr = 1'h1;
				c.write_enable_cmd = 1'h1;
			end
			`OP_STATUS_WRITE: begin
				c.wr = 1'h1;
				c.write_enable_cmd = 1'h1;
			end
			`OP_STATUS_LOW_READ, `OP_STATUS_HIGH_READ, `OP_JEDEC_ID_READ: c.rd = 1'h1;
			`OP_UNIQUE_SERIAL_READ: begin
				c.dmy = 3'h4;
				c.rd = 1'h1;
			end
			`OP_BUSY_INDICATION: c.dmy = 3'h1;
			`OP_SUSPEND_A, `OP_SUSPEND_B, `OP_RESUME_A, `OP_RESUME_B, `OP_WRITE_ENABLE, `OP_WRITE_DISABLE,
			`OP_VOLATILE_WRITE_ENABLE, `OP_RESET_ARM, `OP_RESET, `OP_DEEP_SLEEP_ENTER,
			`OP_LEAVE_ENHANCED: c.known = 1'h1;
			default: c.known = 1'h0;
		endcase
		return c;
	endfunction : decode

	// deselect time after a frame, stretched for recovery periods
	function automatic logic [18:0] post_wait(input logic [7:0] op, input logic wsr_busy);
		logic [18:0] w;
		w = 19'(2 * SCLK_HALF);
		if (op == `OP_DEEP_SLEEP_ENTER)
			w = 19'(`SLEEP_ENTRY_CYC);
		if (op == `OP_DEEP_SLEEP_RELEASE)
			w = 19'(`SLEEP_RELEASE_CYC);
		if (op == `OP_RESET)
			w = wsr_busy ? 19'(STATUS_WRITE_CYC) : 19'(`RESET_RECOVER_CYC);
		return w;
	endfunction : post_wait

	// suspend is held off until the resume gap runs out
	assign take = cmd_valid && cmd_ready &&
		!((cmd_opcode == `OP_SUSPEND_A || cmd_opcode == `OP_SUSPEND_B) && gap_q != '0);
	assign use_wb = (st_q == ST_SHIFT) && need_q && wb_full_q;

	// dual samples append line 1 above line 0
	always_comb begin
		rx_n = dual_q ? {rx_q[5:0], s2_q} : {rx_q[6:0], s2_q[1]};
	end

	// two-flop synchronisers for the data pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {io1_i, io0_i};
			s2_q <= s1_q;
		end
	end

	// one-byte hold for write data; stalls the link when empty
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_q <= '0;
			wb_full_q <= 1'h0;
			wr_ready <= 1'h0;
		end else if (wr_valid && wr_ready) begin
			wb_q <= wr_data;
			wb_full_q <= 1'h1;
			wr_ready <= 1'h0;
		end else if (use_wb) begin
			wb_full_q <= 1'h0;
			wr_ready <= 1'h1;
		end else begin
			wr_ready <= !wb_full_q;
		end
	end

	// resume gap and status write timers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gap_q <= '0;
			wsr_q <= '0;
			erase_last_q <= 1'h0;
		end else begin
			if (ended_q && (op_q == `OP_RESUME_A || op_q == `OP_RESUME_B))
				gap_q <= erase_last_q ? 13'(ERASE_GAP_CYC) : 13'(`PROGRAM_GAP_CYC);
			else if (gap_q != '0)
				gap_q <= gap_q - 1'h1;
			if (ended_q && op_q == `OP_STATUS_WRITE)
				wsr_q <= 19'(STATUS_WRITE_CYC);
			else if (wsr_q != '0)
				wsr_q <= wsr_q - 1'h1;
			if (ended_q && inf_q.write_enable_cmd && op_q != `OP_STATUS_WRITE)
				erase_last_q <= !inf_q.wr;
		end
	end

	// pin drivers follow the shift register one cycle late
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			io0_o <= 1'h0;
			io1_o <= 1'h0;
			io0_oe <= 1'h0;
			io1_oe <= 1'h0;
			dev_busy <= 1'h0;
			cmd_ready <= 1'h0;
			cs_n <= 1'h1;
		end else begin
			io0_o <= dual_q ? sh_q[6] : sh_q[7];
			io1_o <= sh_q[7];
			io0_oe <= (st_q == ST_SHIFT) && (ph_q != PH_RD || !dual_q);
			io1_oe <= (st_q == ST_SHIFT) && (ph_q != PH_RD) && dual_q;
			dev_busy <= (st_q == ST_WATCH) && s2_q[1];
			cmd_ready <= (st_q == ST_IDLE) && !take;
			cs_n <= cs_q; // late like the enables, so select always brackets driven data
		end
	end

	// frame sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= ST_WAIT;
			wait_q <= 19'(`POWERUP_SELECT_CYC);
			cs_q <= 1'h1;
			sclk <= 1'h0;
			ph_q <= PH_OPC;
			inf_q <= '0;
			op_q <= '0;
			main_q <= '0;
			pre_q <= '0;
			addr_q <= '0;
			len_q <= '0;
			sh_q <= '0;
			rx_q <= '0;
			cnt_q <= '0;
			bit_q <= '0;
			div_q <= '0;
			pre_v_q <= 1'h0;
			pend_q <= 1'h0;
			act_q <= 1'h0;
			need_q <= 1'h0;
			dual_q <= 1'h0;
			ended_q <= 1'h0;
			rd_valid <= 1'h0;
			rd_data <= '0;
			cmd_done <= 1'h0;
		end else begin
			rd_valid <= 1'h0;
			cmd_done <= 1'h0;
			ended_q <= 1'h0;
			case (st_q)
				ST_IDLE: begin
					if (take) begin
						main_q <= cmd_opcode;
						addr_q <= cmd_addr;
						len_q <= cmd_len;
						act_q <= 1'h1;
						pend_q <= 1'h1;
						pre_v_q <= decode(cmd_opcode).write_enable_cmd || cmd_opcode == `OP_RESET;
						pre_q <= (cmd_opcode == `OP_RESET) ? `OP_RESET_ARM : `OP_WRITE_ENABLE;
						wait_q <= '0;
						st_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (wait_q != '0) begin
						wait_q <= wait_q - 1'h1;
					end else if (pre_v_q || (pend_q && decode(main_q).known)) begin
						pend_q <= pre_v_q;
						pre_v_q <= 1'h0;
						op_q <= pre_v_q ? pre_q : main_q;
						inf_q <= pre_v_q ? cmd_info_t'(1) : decode(main_q);
						sh_q <= pre_v_q ? pre_q : main_q;
						cs_q <= 1'h0;
						ph_q <= PH_OPC;
						dual_q <= 1'h0;
						bit_q <= 3'h7;
						div_q <= '0;
						st_q <= ST_SHIFT;
					end else begin
						pend_q <= 1'h0;
						cmd_done <= act_q;
						act_q <= 1'h0;
						st_q <= ST_IDLE;
					end
				end
				ST_WATCH: begin
					// let the pin settle through the synchroniser before trusting it
					if (div_q != 8'(SCLK_HALF - 1)) begin
						div_q <= div_q + 1'h1;
					end else if (!s2_q[1]) begin
						cs_q <= 1'h1;
						wait_q <= post_wait(op_q, wsr_q != '0);
						ended_q <= 1'h1;
						st_q <= ST_WAIT;
					end
				end
				ST_SHIFT: begin
					if (need_q) begin
						if (wb_full_q) begin
							sh_q <= wb_q;
							len_q <= len_q - 1'h1;
							need_q <= 1'h0;
							div_q <= '0;
						end
					end else if (div_q != 8'(SCLK_HALF - 1)) begin
						div_q <= div_q + 1'h1;
					end else if (!sclk) begin
						div_q <= '0;
						sclk <= 1'h1;
					end else begin
						div_q <= '0;
						sclk <= 1'h0;
						rx_q <= rx_n;
						if (bit_q != '0) begin
							bit_q <= bit_q - 1'h1;
							sh_q <= dual_q ? {sh_q[5:0], 2'h0} : {sh_q[6:0], 1'h0};
						end else begin
							if (ph_q == PH_RD) begin
								rd_valid <= 1'h1;
								rd_data <= rx_n;
							end
							if ((ph_q == PH_ADR || ph_q == PH_DMY) && cnt_q != '0) begin
								cnt_q <= cnt_q - 1'h1;
								bit_q <= dual_q ? 3'h3 : 3'h7;
								sh_q <= (ph_q == PH_ADR) ? addr_q[23:16] : 8'h00;
								addr_q <= {addr_q[15:0], 8'h00};
							end else if (ph_q == PH_OPC && inf_q.adr != '0) begin
								ph_q <= PH_ADR;
								cnt_q <= 3'({1'h0, inf_q.adr} - 3'h1);
								dual_q <= inf_q.dual_adr;
								bit_q <= inf_q.dual_adr ? 3'h3 : 3'h7;
								sh_q <= addr_q[23:16];
								addr_q <= {addr_q[15:0], 8'h00};
							end else if ((ph_q == PH_OPC || ph_q == PH_ADR) && inf_q.dmy != '0) begin
								ph_q <= PH_DMY;
								cnt_q <= inf_q.dmy - 3'h1;
								dual_q <= inf_q.dual_adr;
								bit_q <= inf_q.dual_adr ? 3'h3 : 3'h7;
								sh_q <= 8'h00;
							end else if (op_q == `OP_BUSY_INDICATION && ph_q == PH_DMY) begin
								st_q <= ST_WATCH;
							end else if (len_q != '0 && (inf_q.rd || inf_q.wr)) begin
								ph_q <= inf_q.rd ? PH_RD : PH_WR;
								dual_q <= inf_q.dual_data;
								bit_q <= inf_q.dual_data ? 3'h3 : 3'h7;
								need_q <= inf_q.wr;
								sh_q <= 8'h00;
								if (inf_q.rd)
									len_q <= len_q - 1'h1;
							end else begin
								cs_q <= 1'h1;
								wait_q <= post_wait(op_q, wsr_q != '0);
								ended_q <= 1'h1;
								st_q <= ST_WAIT;
							end
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule : flash_host

// [shared/flash_host_map.svh]
// opcode, timing and clock count map for the serial flash host
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH
`define OP_ARRAY_READ 8'h03
`define OP_FAST_ARRAY_READ 8'h0B
`define OP_DUAL_OUTPUT_READ 8'h3B
`define OP_DUAL_IO_READ 8'hBB
`define OP_PAGE_ERASE 8'h81
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE_32K 8'h52
`define OP_BLOCK_ERASE_64K 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_PAGE_PROGRAM 8'h02
`define OP_DUAL_INPUT_PROGRAM 8'hA2
`define OP_SUSPEND_A 8'h75
`define OP_SUSPEND_B 8'hB0
`define OP_RESUME_A 8'h7A
`define OP_RESUME_B 8'h30
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_VOLATILE_WRITE_ENABLE 8'h50
`define OP_OTP_AREA_ERASE 8'h44
`define OP_OTP_AREA_PROGRAM 8'h42
`define OP_OTP_AREA_READ 8'h48
`define OP_STATUS_LOW_READ 8'h05
`define OP_STATUS_HIGH_READ 8'h35
`define OP_BUSY_INDICATION 8'h25
`define OP_STATUS_WRITE 8'h01
`define OP_RESET_ARM 8'h66
`define OP_RESET 8'h99
`define OP_JEDEC_ID_READ 8'h9F
`define OP_MAKER_DEVICE_ID_READ 8'h90
`define OP_DUAL_MAKER_DEVICE_ID_READ 8'h92
`define OP_DEEP_SLEEP_ENTER 8'hB9
`define OP_DEEP_SLEEP_RELEASE 8'hAB
`define OP_PARAM_TABLE_READ 8'h5A
`define OP_LEAVE_ENHANCED 8'hFF
`define OP_UNIQUE_SERIAL_READ 8'h4B
`define CLK_PERIOD_NS 40
`define SCLK_HALF_CYC 4
`define T_SLEEP_ENTRY_NS 3000
`define T_SLEEP_RELEASE_NS 8000
`define T_RESET_RECOVER_NS 30000
`define T_STATUS_WRITE_MAX_NS 12000000
`define T_POWERUP_SELECT_NS 70000
`define T_PROGRAM_RESUME_GAP_NS 100000
`define T_ERASE_RESUME_GAP_NS 200000
`define NS_TO_CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_ENTRY_CYC `NS_TO_CYC_UP(`T_SLEEP_ENTRY_NS)
`define SLEEP_RELEASE_CYC `NS_TO_CYC_UP(`T_SLEEP_RELEASE_NS)
`define RESET_RECOVER_CYC `NS_TO_CYC_UP(`T_RESET_RECOVER_NS)
`define STATUS_WRITE_MAX_CYC `NS_TO_CYC_UP(`T_STATUS_WRITE_MAX_NS)
`define POWERUP_SELECT_CYC `NS_TO_CYC_UP(`T_POWERUP_SELECT_NS)
`define PROGRAM_GAP_CYC `NS_TO_CYC_UP(`T_PROGRAM_RESUME_GAP_NS)
`define ERASE_GAP_CYC `NS_TO_CYC_UP(`T_ERASE_RESUME_GAP_NS)
`endif

// [shared/flash_host_pkg.sv]
// types shared by the serial flash host
package flash_host_pkg;
	typedef enum logic [2:0] {PH_OPC, PH_ADR, PH_DMY, PH_WR, PH_RD} phase_t;
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WATCH, ST_WAIT} state_t;
	typedef struct packed {
		logic [1:0] adr;
		logic [2:0] dmy;
		logic dual_adr;
		logic dual_data;
		logic wr;
		logic rd;
		logic write_enable_cmd;
		logic known;
	} cmd_info_t;
endpackage : flash_host_pkg

// [test/flash_host_props.sv]
// assertions on the flash host command port and pins
`timescale 1ns/1ps
module flash_host_props #(
	parameter int SCLK_HALF = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// command port
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_opcode,
	input wire logic cmd_done,
	input wire logic rd_valid,
	// flash pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic io0_oe,
	input wire logic io1_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [10:0] up_q;
	logic [7:0] hi_q;
	logic [7:0] desel_q;
	// cycles since reset, saturating well past the power-up wait
	always_ff @(posedge clk) begin
		if (sys_rst) up_q <= 11'h000;
		else if (up_q != 11'h7ff) up_q <= up_q + 11'h001;
	end
	// length of the running sclk high phase
	always_ff @(posedge clk) hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
	// deselect gap length, saturating so long idles never wrap
	always_ff @(posedge clk) begin
		if (sys_rst) desel_q <= 8'hff;
		else desel_q <= !cs_n ? 8'h00 : (desel_q == 8'hff ? desel_q : desel_q + 8'h01);
	end
	// a non-suspend command taken; suspends may be held off by the resume gap
	sequence s_take;
		cmd_valid && cmd_ready && cmd_opcode != 8'h75 && cmd_opcode != 8'hb0;
	endsequence
	// completion pulse followed by readiness
	sequence s_finish;
		cmd_done ##1 (cmd_ready && !cmd_done);
	endsequence
	a_release_quiet: assert property ($fell(sys_rst) |-> cs_n && !io0_oe && !io1_oe && !cmd_ready)
		else $error("pins not idle after reset");
	a_powerup_wait: assert property ($fell(cs_n) |-> up_q >= 11'h6d6)
		else $error("device selected before power-up wait");
	a_idle_clock: assert property (cs_n |-> !sclk)
		else $error("serial clock not low while deselected");
	a_drive_selected: assert property ((io0_oe || io1_oe) |-> !cs_n)
		else $error("data driven while deselected");
	a_high_phase: assert property ($fell(sclk) |-> hi_q == SCLK_HALF)
		else $error("serial clock high phase wrong length");
	a_deselect_gap: assert property ($fell(cs_n) |-> desel_q >= 2 * SCLK_HALF)
		else $error("deselect gap too short");
	a_take_drop: assert property (s_take |=> !cmd_ready)
		else $error("ready stayed high after a command was taken");
	a_done_ready: assert property (cmd_done |-> s_finish)
		else $error("done pulse not followed by ready");
	a_byte_spacing: assert property (rd_valid |=> !rd_valid [*8])
		else $error("read bytes closer than eight cycles");
endmodule : flash_host_props
bind flash_host flash_host_props #(.SCLK_HALF(SCLK_HALF)) u_props (.clk(clk), .sys_rst(sys_rst),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_done(cmd_done),
	.rd_valid(rd_valid), .cs_n(cs_n), .sclk(sclk), .io0_oe(io0_oe), .io1_oe(io1_oe));

// [test/flash_dev_model.sv]
// behavioural serial flash answering the host controller
`timescale 1ns/1ps
module flash_dev_model #(
	parameter logic [23:0] ID = 24'h12_3456
) (
	// clock used only to scramble released lines and time busy
	input wire logic clk,
	// pins from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic io0_o,
	input wire logic io0_oe,
	input wire logic io1_o,
	input wire logic io1_oe,
	// pins back to the host, and the last byte written
	output logic io0_i,
	output logic io1_i,
	output logic [7:0] last_wr
);
	logic [7:0] op = 8'h00;
	logic [7:0] sh = 8'h00;
	logic [7:0] b;
	logic [23:0] adr = 24'h00_0000;
	logic write_enable_latch = 1'b0, tog = 1'b0, da = 1'b0, dd = 1'b0, rdop = 1'b0, drv = 1'b0, dr0 = 1'b0, dr1 = 1'b0;
	int n = 0, ae = 99, h = 99, k, busy = 0;
	// answer byte; unknown places just echo the address
	function automatic logic [7:0] rb(input int i);
		case (op)
			8'h05: rb = {6'h00, write_enable_latch, busy != 0};
			8'h35: rb = 8'h00;
			8'h9f: rb = 8'(ID >> (16 - 8 * i));
			8'h4b: rb = 8'h3c + 8'(i);
			default: rb = adr[7:0] + 8'(i);
		endcase
	endfunction : rb
	// frame layout per opcode: address end, header end, line use
	task decode(input logic [7:0] o);
		ae = 32;
		h = 32;
		da = 1'b0;
		dd = 1'b0;
		rdop = 1'b1;
		case (o)
			8'h0b, 8'h48, 8'h5a: h = 40;
			8'h3b, 8'h92: begin h = 40; dd = 1'b1; end
			8'hbb: begin ae = 20; h = 24; da = 1'b1; dd = 1'b1; end
			8'h03, 8'h90, 8'hab: ;
			8'h02, 8'h42: rdop = 1'b0;
			8'h81, 8'h20, 8'h52, 8'hd8, 8'h44: rdop = 1'b0;
			8'h4b: begin ae = 8; h = 40; end
			8'ha2: begin rdop = 1'b0; dd = 1'b1; end
			8'h25: begin ae = 8; h = 16; end
			default: begin ae = 8; h = 8; rdop = o != 8'h01; end
		endcase
	endtask : decode
	// rising edges: opcode, address, then host data bytes
	always @(posedge sclk) begin
		if (n < 8) op = {op[6:0], io0_o};
		else if (n < ae && da) adr = {adr[21:0], io1_o, io0_o};
		else if (n < ae) adr = {adr[22:0], io0_o};
		else if (n >= h && !rdop && dd) sh = {sh[5:0], io1_o, io0_o};
		else if (n >= h && !rdop) sh = {sh[6:0], io0_o};
		if (n >= h && !rdop && (n - h) % (dd ? 4 : 8) == (dd ? 3 : 7)) last_wr = sh;
		if (n == 7) decode(op);
		n++;
	end
	// falling edges: next bit out, msb or msb pair first
	always @(negedge sclk) if (!cs_n && rdop && n >= h) begin
		k = n - h;
		b = rb(dd ? k / 4 : k / 8);
		dr1 = dd ? b[7 - 2 * (k % 4)] : b[7 - k % 8];
		dr0 = b[6 - 2 * (k % 4)];
		drv = 1'b1;
	end
	// deselect closes the frame and starts any internal cycle
	always @(posedge cs_n) begin
		if (n >= 8 && op == 8'h06) write_enable_latch = 1'b1;
		if (n >= 8 && op == 8'h04) write_enable_latch = 1'b0;
		if (n >= 8 && write_enable_latch && op inside {8'h02, 8'ha2, 8'h42, 8'h01, 8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h44})
			busy = 400;
		if (n >= 8 && op == 8'h99) write_enable_latch = 1'b0;
		n = 0;
		h = 99;
		ae = 99;
		drv = 1'b0;
	end
	// internal cycle timer; latch drops when the cycle ends
	always @(posedge clk) begin
		tog <= ~tog;
		if (busy == 1) write_enable_latch = 1'b0;
		if (busy != 0) busy = busy - 1;
	end
	// released lines toggle so stale values never look valid
	assign io1_i = io1_oe ? io1_o : (op == 8'h25 && n >= 16 && !cs_n) ? busy != 0 : (drv ? dr1 : tog);
	assign io0_i = io0_oe ? io0_o : (drv && dd ? dr0 : tog);
endmodule : flash_dev_model

// [test/flash_host_test.sv]
// self-checking bench for the serial flash host
`timescale 1ns/1ps
module flash_host_test;
	localparam logic [23:0] DEV_ID = 24'h5a_c317; // arbitrary identity value
	logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0;
	logic [7:0] cmd_opcode = 8'h00, wr_data = 8'h00, rd_data, last_wr, wb;
	logic [23:0] cmd_addr = 24'h00_0000, a;
	logic [15:0] cmd_len = 16'h0000;
	logic cmd_ready, cmd_done, wr_ready, rd_valid, dev_busy, cs_n, sclk;
	logic busy_seen = 1'b0;
	logic io0_o, io0_oe, io1_o, io1_oe, io0_i, io1_i;
	logic [31:0] seed = 32'h0000_7e0e;
	logic [7:0] got[$];
	logic [7:0] rops[8] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'h48, 8'h90, 8'h92, 8'h5a};
	logic [7:0] eops[7] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h44};
	logic [7:0] pops[4] = '{8'h02, 8'ha2, 8'h42, 8'h01};
	int fails = 0, tests_run = 0, i, len;
	// 25 MHz system clock
	always #20 clk = ~clk;
	flash_host #(.STATUS_WRITE_CYC(200), .ERASE_GAP_CYC(50)) dut (.clk(clk), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .cmd_done(cmd_done), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .dev_busy(dev_busy), .cs_n(cs_n), .sclk(sclk), .io0_o(io0_o),
		.io0_oe(io0_oe), .io0_i(io0_i), .io1_o(io1_o), .io1_oe(io1_oe), .io1_i(io1_i));
	flash_dev_model #(.ID(DEV_ID)) u_dev (.clk(clk), .cs_n(cs_n), .sclk(sclk), .io0_o(io0_o), .io0_oe(io0_oe),
		.io1_o(io1_o), .io1_oe(io1_oe), .io0_i(io0_i), .io1_i(io1_i), .last_wr(last_wr));
	// xorshift source, fixed start for repeatable runs
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// expected answer byte
	function automatic logic [7:0] expb(input logic [7:0] op, input logic [23:0] adr, input int k,
		input logic [7:0] st);
		if (op == 8'h9f) return 8'(DEV_ID >> (16 - 8 * k));
		if (op == 8'h05) return st;
		if (op == 8'h4b) return 8'h3c + 8'(k);
		return adr[7:0] + 8'(k);
	endfunction : expb
	// byte comparison
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// verdict and end of run
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim
	// one command; feeds wn write bytes and gathers read bytes until done
	task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input int n, input int wn);
		int k, taken;
		logic done;
		logic seen;
		done = 1'b0;
		seen = 1'b0;
		busy_seen = 1'b0;
		taken = 0;
		got.delete();
		cmd_opcode <= op;
		cmd_addr <= adr;
		cmd_len <= 16'(n);
		cmd_valid <= 1'b1;
		wr_valid <= wn > 0;
		wr_data <= wb;
		for (k = 0; k < 20000 && !done; k++) begin
			@(posedge clk);
			// ready stays high while a suspend is held off; drop valid only once ready falls
			if (seen && cmd_ready === 1'b0) cmd_valid <= 1'b0;
			seen = cmd_ready === 1'b1;
			if (dev_busy === 1'b1) busy_seen = 1'b1;
			if (wr_valid && wr_ready === 1'b1) begin
				taken++;
				wr_data <= wr_data + 8'h11;
				if (taken == wn) wr_valid <= 1'b0;
			end
			if (rd_valid === 1'b1) got.push_back(rd_data);
			done = cmd_done === 1'b1;
		end
		chk("command done", 8'h01, {7'h00, done});
		if (!done) end_sim();
	endtask : cmd
	// read command with every byte compared
	task automatic rd(input logic [7:0] op, input logic [23:0] adr, input int n, input logic [7:0] st);
		int k;
		cmd(op, adr, n, 0);
		chk("byte count", 8'(n), 8'(got.size()));
		for (k = 0; k < n; k++) chk("read byte", expb(op, adr, k, st), got[k]);
	endtask : rd
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h9f, 24'h00_0000, 3, 8'h00);
		cmd(8'h06, 24'h00_0000, 0, 0);
		rd(8'h05, 24'h00_0000, 1, 8'h02);
		cmd(8'h04, 24'h00_0000, 0, 0);
		rd(8'h35, 24'h00_0000, 1, 8'h00);
		rd(8'h05, 24'h00_0000, 1, 8'h00);
		rd(8'h03, 24'hff_ffff, 2, 8'h00);
		for (i = 0; i < 8; i++) begin
			a = 24'(rnd());
			len = 1 + int'(rnd() % 4);
			rd(rops[i], a, len, 8'h00);
		end
		for (i = 0; i < 4; i++) begin
			wb = 8'(rnd());
			len = 1 + int'(rnd() % 2);
			cmd(pops[i], 24'(rnd()), len, len);
			chk("written byte", 8'(wb + 8'h11 * (len - 1)), last_wr);
			rd(8'h05, 24'h00_0000, 1, 8'h03);
			cmd(8'h25, 24'h00_0000, 0, 0);
			chk("busy indication", 8'h01, {7'h00, busy_seen});
			rd(8'h05, 24'h00_0000, 1, 8'h00);
		end
		for (i = 0; i < 7; i++) begin
			cmd(eops[i], 24'(rnd()), 0, 0);
			rd(8'h05, 24'h00_0000, 1, 8'h03);
			cmd(8'h25, 24'h00_0000, 0, 0);
			chk("busy indication", 8'h01, {7'h00, busy_seen});
		end
		cmd(8'he7, 24'h00_0000, 0, 0);
		chk("ignored bytes", 8'h00, 8'(got.size()));
		cmd(8'hb9, 24'h00_0000, 0, 0);
		rd(8'hab, 24'h00_0042, 1, 8'h00);
		cmd(8'h50, 24'h00_0000, 0, 0);
		cmd(8'h7a, 24'h00_0000, 0, 0);
		cmd(8'hb0, 24'h00_0000, 0, 0);
		cmd(8'hff, 24'h00_0000, 0, 0);
		rd(8'h4b, 24'h00_0000, 2, 8'h00);
		cmd(8'h06, 24'h00_0000, 0, 0);
		cmd(8'h99, 24'h00_0000, 0, 0);
		rd(8'h05, 24'h00_0000, 1, 8'h00);
		end_sim();
	end
endmodule : flash_host_test
